// ### verilog/pmic_regs_map.svh
// register offsets, field positions, reset values and timing for the
// power-good register slice; assumes an 8-bit register address space
`ifndef PMIC_REGS_MAP_SVH
`define PMIC_REGS_MAP_SVH

`define ADDR_UNLOCK_KEY 8'h0B
`define ADDR_RAIL_GOOD 8'h0C
`define ADDR_GOOD_PIN_CTRL 8'h0D
`define ADDR_BUCK1_SETTING 8'h0E

`define UNLOCK_CODE 8'h7D
`define UNLOCK_KEY_RESET 8'h00
`define GOOD_PIN_CTRL_RESET 8'h0C
`define GOOD_PIN_CTRL_WMASK 8'h0F
`define BUCK1_SETTING_WMASK 8'hBF
`define ZERO_BYTE 8'h00

`define LIN1_MASK_BIT 3
`define LIN2_MASK_BIT 2
`define BUCK1_XADJ_BIT 7
`define DLY_SEL_HI 1
`define DLY_SEL_LO 0
`define STAT_SW1_BIT 6
`define STAT_SW2_BIT 5
`define STAT_BUCK1_BIT 4
`define STAT_BUCK2_BIT 3
`define STAT_BUCK3_BIT 2
`define STAT_LIN1_BIT 1
`define STAT_LIN2_BIT 0
`define VCODE_HI 5
`define VCODE_LO 0

// delays in milliseconds at a 4 ns clock: 250000 cycles per ms
`define CLK_PER_MS 250000
`define DLY_MS_0 20
`define DLY_MS_1 100
`define DLY_MS_2 200
`define DLY_MS_3 400
`define DLY_CNT_W 27

`endif

// ### verilog/pmic_regs_pkg.sv
// types for the power-good register slice
// assumes pmic_regs_map.svh holds all numbers
package pmic_regs_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic [1:0] {
        DLY_20MS = 2'b00,
        DLY_100MS = 2'b01,
        DLY_200MS = 2'b10,
        DLY_400MS = 2'b11
    } good_delay_t;
    typedef enum logic [0:0] {
        PIN_LOW = 1'b0,
        PIN_HIGH = 1'b1
    } pin_state_t;
endpackage

// ### verilog/pmic_password_powergood_regs.sv
// password unlock, power-good status, power-good pin control and buck-1
// setting registers of a power-management chip.
// assumes an i2c slave front end that gives one-cycle write/read strobes
// with address and data, and a one-cycle pulse at the end of each transaction.
//
// Overview of operation
// - unlock code lets next write reach protected
// - any other key keeps protected registers locked
// - key clears after following transaction completes
// - status bit high when rail in regulation
// - switch-configured rails also report good
// - linear rail 1 mask clear lets it drop pin
// - linear rail 2 mask clear lets it drop pin
// - delay code selects 20/100/200/400 ms
// - 0x0D and 0x0E are password protected
// - buck1 layout: adjust, unused, six-bit code
// - adjust bit selects register or external voltage
`timescale 1ns/10ps
`include "pmic_regs_map.svh"

module pmic_password_powergood_regs #(
    parameter logic [7:0] BUCK1_RESET = 8'h1E,  // variant dependent, arbitrary default
    parameter int unsigned CLK_PER_MS = `CLK_PER_MS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire pmic_regs_pkg::reg_byte_t reg_addr,
    input wire pmic_regs_pkg::reg_byte_t wr_data,
    input wire logic xfer_done,
    input wire logic switch_rail1_good,
    input wire logic switch_rail2_good,
    input wire logic buck1_good,
    input wire logic buck2_good,
    input wire logic buck3_good,
    input wire logic linear_rail1_good,
    input wire logic linear_rail2_good,
    input wire logic switch_rail1_is_switch,
    input wire logic switch_rail2_is_switch,
    output pmic_regs_pkg::reg_byte_t rd_data,
    output logic power_good_out_pin,
    output logic buck1_external_adjust,
    output logic [5:0] buck1_voltage_code
);
    import pmic_regs_pkg::*;

    // ************************************************************
    // register file
    // ************************************************************
    reg_byte_t unlock_key_r, unlock_key_nxt;
    reg_byte_t good_ctrl_r, good_ctrl_nxt;
    reg_byte_t buck1_r, buck1_nxt;
    reg_byte_t status_r, status_nxt;
    reg_byte_t rd_data_r, rd_data_nxt;
    logic armed_r, armed_nxt;
    // set by the one protected write that a key allows; a burst gets no more
    logic spent_r, spent_nxt;
    logic unlocked;
    good_delay_t dly_sel;

    assign unlocked = (unlock_key_r == `UNLOCK_CODE) && !spent_r;
    assign dly_sel = good_delay_t'(good_ctrl_r[`DLY_SEL_HI:`DLY_SEL_LO]);

    // live status snapshot; switch-configured rails count as good
    // one cycle of lag here is where the pin delay starts counting
    always_comb begin
        status_nxt = `ZERO_BYTE;
        status_nxt[`STAT_SW1_BIT] = switch_rail1_good | switch_rail1_is_switch;
        status_nxt[`STAT_SW2_BIT] = switch_rail2_good | switch_rail2_is_switch;
        status_nxt[`STAT_BUCK1_BIT] = buck1_good;
        status_nxt[`STAT_BUCK2_BIT] = buck2_good;
        status_nxt[`STAT_BUCK3_BIT] = buck3_good;
        status_nxt[`STAT_LIN1_BIT] = linear_rail1_good;
        status_nxt[`STAT_LIN2_BIT] = linear_rail2_good;
    end

    // writes, protection and key self-clear
    // a key opens one protected write only: a multi-byte burst after it
    // would otherwise walk through both protected registers
    always_comb begin
        unlock_key_nxt = unlock_key_r;
        good_ctrl_nxt = good_ctrl_r;
        buck1_nxt = buck1_r;
        armed_nxt = armed_r;
        spent_nxt = spent_r;
        if (wr_stb) begin
            case (reg_addr)
                `ADDR_UNLOCK_KEY: begin
                    unlock_key_nxt = wr_data;
                    armed_nxt = 1'b0;  // this transaction is the key write itself
                    spent_nxt = 1'b0;
                end
                `ADDR_GOOD_PIN_CTRL: begin
                    if (unlocked) begin
                        good_ctrl_nxt = wr_data & `GOOD_PIN_CTRL_WMASK;
                        spent_nxt = 1'b1;
                    end
                end
                `ADDR_BUCK1_SETTING: begin
                    if (unlocked) begin
                        buck1_nxt = wr_data & `BUCK1_SETTING_WMASK;
                        spent_nxt = 1'b1;
                    end
                end
                default: begin
                    // status register and unmapped: writes dropped
                    unlock_key_nxt = unlock_key_r;
                end
            endcase
        end
        // key lives through its own transaction and the next one
        if (xfer_done) begin
            if (armed_r) begin
                unlock_key_nxt = `UNLOCK_KEY_RESET;
                spent_nxt = 1'b0;
                armed_nxt = 1'b0;
            end else if (unlock_key_r != `UNLOCK_KEY_RESET ||
                         (wr_stb && reg_addr == `ADDR_UNLOCK_KEY)) begin
                armed_nxt = 1'b1;
            end
        end
    end

    // read mux registered so the data port comes from a flop
    // unmapped addresses read zero rather than a stale byte
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_stb) begin
            case (reg_addr)
                `ADDR_UNLOCK_KEY: rd_data_nxt = unlock_key_r;
                `ADDR_RAIL_GOOD: rd_data_nxt = status_r;
                `ADDR_GOOD_PIN_CTRL: rd_data_nxt = good_ctrl_r;
                `ADDR_BUCK1_SETTING: rd_data_nxt = buck1_r;
                default: rd_data_nxt = `ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            unlock_key_r <= `UNLOCK_KEY_RESET;
            good_ctrl_r <= `GOOD_PIN_CTRL_RESET;
            buck1_r <= BUCK1_RESET;
            status_r <= `ZERO_BYTE;
            rd_data_r <= `ZERO_BYTE;
            armed_r <= 1'b0;
            spent_r <= 1'b0;
        end else begin
            unlock_key_r <= unlock_key_nxt;
            good_ctrl_r <= good_ctrl_nxt;
            buck1_r <= buck1_nxt;
            status_r <= status_nxt;
            rd_data_r <= rd_data_nxt;
            armed_r <= armed_nxt;
            spent_r <= spent_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign buck1_external_adjust = buck1_r[`BUCK1_XADJ_BIT];
    assign buck1_voltage_code = buck1_r[`VCODE_HI:`VCODE_LO];

    // ************************************************************
    // power-good pin
    // ************************************************************
    // cycle counts fixed at elaboration; the counter width holds the longest
    // delay at the full clock rate, so the count can never wrap
    localparam logic [`DLY_CNT_W-1:0] DLY_CYC_0 = `DLY_CNT_W'(`DLY_MS_0 * CLK_PER_MS);
    localparam logic [`DLY_CNT_W-1:0] DLY_CYC_1 = `DLY_CNT_W'(`DLY_MS_1 * CLK_PER_MS);
    localparam logic [`DLY_CNT_W-1:0] DLY_CYC_2 = `DLY_CNT_W'(`DLY_MS_2 * CLK_PER_MS);
    localparam logic [`DLY_CNT_W-1:0] DLY_CYC_3 = `DLY_CNT_W'(`DLY_MS_3 * CLK_PER_MS);

    logic [`DLY_CNT_W-1:0] dly_cnt_r, dly_cnt_nxt, dly_target;
    logic pin_r, pin_nxt;
    logic all_good;

    // masked linear rails drop out of the combined good term
    // the switch and buck rails have no mask and always count
    assign all_good = status_r[`STAT_SW1_BIT] & status_r[`STAT_SW2_BIT]
        & status_r[`STAT_BUCK1_BIT] & status_r[`STAT_BUCK2_BIT] & status_r[`STAT_BUCK3_BIT]
        & (status_r[`STAT_LIN1_BIT] | good_ctrl_r[`LIN1_MASK_BIT])
        & (status_r[`STAT_LIN2_BIT] | good_ctrl_r[`LIN2_MASK_BIT]);

    always_comb begin
        case (dly_sel)
            DLY_20MS: dly_target = DLY_CYC_0;
            DLY_100MS: dly_target = DLY_CYC_1;
            DLY_200MS: dly_target = DLY_CYC_2;
            DLY_400MS: dly_target = DLY_CYC_3;
            default: dly_target = DLY_CYC_0;
        endcase
    end

    // counter restarts on any bad sample, so glitches re-arm the full delay
    // the count parks at its end value while good, so it cannot run away
    always_comb begin
        dly_cnt_nxt = dly_cnt_r;
        pin_nxt = pin_r;
        if (!all_good) begin
            dly_cnt_nxt = '0;
            pin_nxt = PIN_LOW;
        end else if (dly_cnt_r >= dly_target - `DLY_CNT_W'(1)) begin
            pin_nxt = PIN_HIGH;
        end else begin
            dly_cnt_nxt = dly_cnt_r + `DLY_CNT_W'(1);
        end
    end

    // pin and counter share one reset so the pin never starts high
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dly_cnt_r <= '0;
            pin_r <= PIN_LOW;
        end else begin
            dly_cnt_r <= dly_cnt_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign power_good_out_pin = pin_r;
endmodule

// ### bench/pmic_regs_chk.sv
// checker for the power-good slice: pin timing, read data, buck field
// assumes it is bound onto the register slice and sees only its ports
`timescale 1ns/10ps
module pmic_regs_chk #(parameter int unsigned CLK_PER_MS = 250000) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire pmic_regs_pkg::reg_byte_t reg_addr,
    input wire pmic_regs_pkg::reg_byte_t wr_data,
    input wire pmic_regs_pkg::reg_byte_t rd_data,
    input wire logic switch_rail1_good,
    input wire logic switch_rail2_good,
    input wire logic buck1_good,
    input wire logic buck2_good,
    input wire logic buck3_good,
    input wire logic linear_rail1_good,
    input wire logic linear_rail2_good,
    input wire logic switch_rail1_is_switch,
    input wire logic switch_rail2_is_switch,
    input wire logic power_good_out_pin,
    input wire logic buck1_external_adjust,
    input wire logic [5:0] buck1_voltage_code
);
    import pmic_regs_pkg::*;
    logic bucks_ok, sw_ok;
    logic [7:0] stat;
    int run_r, run_nxt;
    // ***********************************************
    // unmaskable rails and good-run counter
    // ***********************************************
    assign bucks_ok = buck1_good & buck2_good & buck3_good;
    assign sw_ok = (switch_rail1_good | switch_rail1_is_switch)
        & (switch_rail2_good | switch_rail2_is_switch);
    assign stat = {1'b0, switch_rail1_good | switch_rail1_is_switch,
        switch_rail2_good | switch_rail2_is_switch, buck1_good, buck2_good,
        buck3_good, linear_rail1_good, linear_rail2_good};
    // masks are internal, so only a lower bound on the rise is checkable
    always_comb begin
        run_nxt = (bucks_ok & sw_ok) ? run_r + 1 : 0;
    end
    always_ff @(posedge ref_clk) begin
        run_r <= rst_n ? run_nxt : 0;
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_buck_drop: assert property (!bucks_ok |-> ##2 !power_good_out_pin)
        else $error("pin stayed high after a buck rail dropped");
    a_switch_drop: assert property (!sw_ok |-> ##2 !power_good_out_pin)
        else $error("pin stayed high after a switch rail dropped");
    a_pin_delay: assert property ($rose(power_good_out_pin) |-> run_r >= 20 * CLK_PER_MS)
        else $error("pin rose before the shortest delay");
    a_pin_reset: assert property ($rose(rst_n) |-> !power_good_out_pin)
        else $error("pin high out of reset");
    a_rd_reset: assert property ($rose(rst_n) |-> rd_data == 8'h00)
        else $error("read data not clear out of reset");
    a_status_read: assert property (rd_stb && reg_addr == 8'h0C |=> rd_data == $past(stat, 2))
        else $error("status read does not match the rails");
    a_rd_hold: assert property (!rd_stb |=> $stable(rd_data))
        else $error("read data moved without a read");
    a_buck_source: assert property (!$stable({buck1_external_adjust, buck1_voltage_code})
        |-> $past(wr_stb && reg_addr == 8'h0E)
        && {buck1_external_adjust, buck1_voltage_code} == $past({wr_data[7], wr_data[5:0]}))
        else $error("buck field changed without a write to it");
    c_pin_up: cover property ($rose(power_good_out_pin));
    c_buck_set: cover property (!$stable(buck1_voltage_code));
    c_status_rd: cover property (rd_stb && reg_addr == 8'h0C);
endmodule
bind pmic_password_powergood_regs pmic_regs_chk #(.CLK_PER_MS(CLK_PER_MS)) u_chk (
    .ref_clk, .rst_n, .wr_stb, .rd_stb, .reg_addr, .wr_data, .rd_data, .switch_rail1_good,
    .switch_rail2_good, .buck1_good, .buck2_good, .buck3_good, .linear_rail1_good,
    .linear_rail2_good, .switch_rail1_is_switch, .switch_rail2_is_switch,
    .power_good_out_pin, .buck1_external_adjust, .buck1_voltage_code);

// ### bench/pmic_host.sv
// host model: one-byte and two-byte transactions on the strobe bus, each closed by a stop
// assumes the slice samples on the rising edge; this side moves on the falling
`timescale 1ns/10ps
module pmic_host (
    input wire logic ref_clk,
    output logic wr_stb,
    output logic rd_stb,
    output logic xfer_done,
    output pmic_regs_pkg::reg_byte_t reg_addr,
    output pmic_regs_pkg::reg_byte_t wr_data
);
    import pmic_regs_pkg::*;
    reg_byte_t exp_q[$];
    initial begin
        {wr_stb, rd_stb, xfer_done} = 3'b000;
        {reg_addr, wr_data} = 16'h0000;
    end
    // ***********************************************
    // a key write and the next write are two transactions
    // ***********************************************
    task automatic xfer(input logic w, input reg_byte_t a, d);
        @(negedge ref_clk);
        {wr_stb, rd_stb, reg_addr, wr_data} = {w, !w, a, d};
        if (!w) exp_q.push_back(d);
        @(negedge ref_clk);
        {wr_stb, rd_stb, xfer_done} = 3'b001;
        {reg_addr, wr_data} = ~{a, d};  // released bus never keeps the old value
        @(negedge ref_clk);
        xfer_done = 1'b0;
    endtask
    // two write bytes in one transaction; the strobe stays up between them
    task automatic burst(input reg_byte_t a0, d0, a1, d1);
        @(negedge ref_clk);
        {wr_stb, rd_stb, reg_addr, wr_data} = {1'b1, 1'b0, a0, d0};
        @(negedge ref_clk);
        {reg_addr, wr_data} = {a1, d1};
        @(negedge ref_clk);
        {wr_stb, xfer_done} = 2'b01;
        {reg_addr, wr_data} = ~{a1, d1};
        @(negedge ref_clk);
        xfer_done = 1'b0;
    endtask
endmodule

// ### bench/pmic_password_powergood_regs_tb.sv
// self-checking bench: host model on the register side, bench on the rails
// assumes a shortened millisecond count so all four delays fit the run
`timescale 1ns/10ps
module pmic_password_powergood_regs_tb;
    import pmic_regs_pkg::*;
    localparam int CPM = 10;
    localparam reg_byte_t B1 = 8'h25;  // variant reset, arbitrary
    logic ref_clk = 0, rst_n = 0, seen_r = 0, pin, xadj, wr_stb, rd_stb, xfer_done;
    logic [5:0] code;
    logic [6:0] rg = 0;  // rail goods in status bit order
    logic [1:0] sw = 0;
    reg_byte_t reg_addr, wr_data, rd_data;
    reg_byte_t keys[4] = '{8'h00, 8'h7C, 8'h7E, 8'hFF};
    int ms[4] = '{20, 100, 200, 400};
    int miscompares = 0, tests_run = 0;
    int unsigned seed = 71189;
    always #2 ref_clk = ~ref_clk;
    pmic_host u_host (.ref_clk, .wr_stb, .rd_stb, .xfer_done, .reg_addr, .wr_data);
    pmic_password_powergood_regs #(.BUCK1_RESET(B1), .CLK_PER_MS(CPM)) u_dut (
        .ref_clk, .rst_n, .wr_stb, .rd_stb, .reg_addr, .wr_data, .xfer_done,
        .switch_rail1_good(rg[6]), .switch_rail2_good(rg[5]), .buck1_good(rg[4]),
        .buck2_good(rg[3]), .buck3_good(rg[2]), .linear_rail1_good(rg[1]),
        .linear_rail2_good(rg[0]), .switch_rail1_is_switch(sw[1]),
        .switch_rail2_is_switch(sw[0]), .rd_data, .power_good_out_pin(pin),
        .buck1_external_adjust(xadj), .buck1_voltage_code(code));
    // ***********************************************
    // helpers
    // ***********************************************
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input reg_byte_t seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input reg_byte_t a, d);
        u_host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input reg_byte_t a, e);
        u_host.xfer(1'b0, a, e);
    endtask
    task automatic pin_is(input logic e, input int n);
        repeat (n) @(negedge ref_clk);
        chk(8'(pin), 8'(e));
    endtask
    // read data settles by the falling edge after the strobe was taken
    always @(posedge ref_clk) seen_r <= rd_stb;
    always @(negedge ref_clk) if (seen_r) chk(rd_data, u_host.exp_q.pop_front());
    // generous bound: all four delays plus the register traffic
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        close_out();
    end
    // ***********************************************
    // main sequence
    // ***********************************************
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1;
        rd(8'h0B, 8'h00);
        rd(8'h0D, 8'h0C);
        rd(8'h0E, B1);
        foreach (keys[i]) begin
            wr(8'h0B, keys[i]);
            wr(8'h0D, 8'h00);
            wr(8'h0E, 8'h00);
            rd(8'h0D, 8'h0C);
            rd(8'h0E, B1);
        end
        wr(8'h0B, 8'h7D);
        wr(8'h0E, 8'hFF);
        chk({xadj, 1'b0, code}, 8'hBF);
        rd(8'h0E, 8'hBF);
        wr(8'h0E, 8'h00);
        wr(8'h0B, 8'h7D);
        rd(8'h0B, 8'h7D);
        rd(8'h0B, 8'h00);
        wr(8'h0D, 8'h00);
        rd(8'h0D, 8'h0C);
        rd(8'h0E, 8'hBF);
        // one key, two protected bytes in one burst: only the first lands
        wr(8'h0B, 8'h7D);
        u_host.burst(8'h0D, 8'h05, 8'h0E, 8'h00);
        rd(8'h0D, 8'h05);
        rd(8'h0E, 8'hBF);
        repeat (8) begin
            {rg, sw} = 9'(xs());
            wr(8'h0C, 8'(xs()));
            rd(8'h0C, {1'b0, rg[6] | sw[1], rg[5] | sw[0], rg[4:0]});
        end
        // each pass: one delay code and one pair of linear masks
        for (int i = 0; i < 4; i++) begin
            {rg, sw} = 9'h000;
            wr(8'h0B, 8'h7D);
            wr(8'h0D, {4'h0, i[0], i[1], i[1:0]});
            {rg, sw} = 9'h1FC;
            pin_is(1'b0, ms[i] * CPM - 4);
            pin_is(1'b1, 8);
            rg[1:0] = 2'b00;
            pin_is(i == 3, 3);
        end
        rg[4] = 1'b0;
        pin_is(1'b0, 3);
        close_out();
    end
endmodule
